// ==== rtl/srct_params.svh ====
`ifndef SRCT_PARAMS_SVH
`define SRCT_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the Wishbone slave
// ****************************************************************
`define SRCT_OFF_SDRAM 8'h00
`define SRCT_OFF_CARD 8'h04
`define SRCT_OFF_STATUS 8'h08

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define SRCT_SDRAM_RST 16'h0000
`define SRCT_CARD_RST 16'h0000
`define SRCT_SDRAM_WMASK 16'hfffe
`define SRCT_CARD_WMASK 16'hcfff

// ****************************************************************
// SDRAM control field positions and row-multiplex codes
// ****************************************************************
`define SRCT_BIT_REFRESH_EN 2
`define SRCT_BIT_REFRESH_KIND 1
`define SRCT_AMX_LSB 3
`define SRCT_AMX_A10_X16 4'hd
`define SRCT_AMX_A11_X16 4'he
`define SRCT_AMX_A9_X16 4'h4
`define SRCT_AMX_A10_X8 4'h5
`define SRCT_AMX_A9_X32 4'h7

// ****************************************************************
// Card strobe timing field positions (MSB bit, low pair base)
// ****************************************************************
`define SRCT_A6_WAIT_TOP 15
`define SRCT_A5_WAIT_TOP 14
`define SRCT_A5_ASSERT_MSB 11
`define SRCT_A6_ASSERT_MSB 10
`define SRCT_A5_HOLD_MSB 9
`define SRCT_A6_HOLD_MSB 8
`define SRCT_A5_ASSERT_LO 6
`define SRCT_A6_ASSERT_LO 4
`define SRCT_A5_HOLD_LO 2
`define SRCT_A6_HOLD_LO 0

`endif

// ==== rtl/srct_pkg.sv ====
package srct_pkg;

    // ****************************************************************
    // State encodings, Gray along the usual path
    // ****************************************************************
    typedef enum logic [1:0] {
        RF_IDLE = 2'b00,
        RF_HOLD = 2'b01,
        RF_AUTO = 2'b11,
        RF_SELF = 2'b10
    } srct_rf_state_t;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b000,
        CS_SETUP = 3'b001,
        CS_STROBE = 3'b011,
        CS_BURST = 3'b010,
        CS_HOLD = 3'b110
    } srct_card_state_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic start;
        logic write;
        logic [1:0] beats;
    } srct_card_req_t;

    typedef struct packed {
        logic [5:0] first_waits;
        logic [5:0] burst_states;
        logic pin_ignored;
    } srct_wait_t;

endpackage

// ==== rtl/srct_wait_decode.sv ====
`timescale 1ns/1ps
module srct_wait_decode (
    input wire logic [3:0] code_in,
    output srct_pkg::srct_wait_t wait_out
);
    import srct_pkg::*;

    // ****************************************************************
    // Four-bit wait code to wait and burst-state counts
    // ****************************************************************
    logic [5:0] waits;

    // First-cycle wait table
    always_comb
    begin
        case (code_in)
            4'h0: waits = 6'h00;
            4'h1: waits = 6'h01;
            4'h2: waits = 6'h02;
            4'h3: waits = 6'h03;
            4'h4: waits = 6'h04;
            4'h5: waits = 6'h06;
            4'h6: waits = 6'h08;
            4'h7: waits = 6'h0a;
            4'h8: waits = 6'h0c;
            4'h9: waits = 6'h0e;
            4'ha: waits = 6'h12;
            4'hb: waits = 6'h16;
            4'hc: waits = 6'h1a;
            4'hd: waits = 6'h1e;
            4'he: waits = 6'h22;
            default: waits = 6'h26;
        endcase
    end

    // Burst beats take one state more than the waits, floor of two
    assign wait_out.first_waits = waits;
    assign wait_out.burst_states = (code_in <= 4'h1) ? 6'h02 : 6'(waits + 6'h01);
    assign wait_out.pin_ignored = (code_in == 4'h0);
endmodule

// ==== rtl/srct_half_cycle_stage.sv ====
`timescale 1ns/1ps
module srct_half_cycle_stage (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic strobe_in,
    input wire logic write_in,
    output logic oe_n_out,
    output logic we_n_out
);
    import srct_pkg::*;

    // ****************************************************************
    // Falling-edge retime of the card strobes
    // ****************************************************************
    // Moving the strobe half a cycle off the address gives the .5 steps
    always_ff @(negedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
        end
        else
        begin
            oe_n_out <= ~(strobe_in & ~write_in);
            we_n_out <= ~(strobe_in & write_in);
        end
    end
endmodule

// ==== rtl/srct_top.sv ====
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "srct_params.svh"
module srct_top (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic manual_rstn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [11:0] sdram_addr_in,
    input wire logic row_phase_in,
    output logic row_a1_out,
    input wire logic refresh_req_in,
    input wire logic ext_bus_busy_in,
    output logic auto_refresh_out,
    output logic self_refresh_out,
    output logic interval_tick_out,
    input wire logic [1:0][2:0] wait_low_bits_in,
    input srct_pkg::srct_card_req_t [1:0] card_req_in,
    input wire logic [1:0] card_wait_pin_in,
    output logic [1:0] card_addr_valid_out,
    output logic [1:0] card_oe_n_out,
    output logic [1:0] card_we_n_out,
    output logic [1:0] card_beat_done_out,
    output logic [1:0] card_done_out,
    output logic [1:0] card_busy_out
);
    import srct_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [15:0] sdram_q;
    logic [15:0] card_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic wr_req;
    logic hit_sdram;
    logic hit_card;
    logic [15:0] status;
    logic rf_en;
    logic rf_kind;
    logic [3:0] amx;
    logic amx_valid;
    logic row_bit;
    logic row_a1_q;
    logic bus_busy;
    srct_rf_state_t rf_q;
    logic auto_q;
    logic tick_q;
    logic [1:0][3:0] wait_code;
    logic [1:0][2:0] assert_dly;
    logic [1:0][2:0] hold_dly;
    srct_wait_t [1:0] wait_info;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    // One wait state: ack one cycle after the strobe, dropped the next
    assign wr_req = wb_cyc_in & wb_stb_in & wb_we_in & ~ack_q;
    assign hit_sdram = (wb_adr_in == `SRCT_OFF_SDRAM);
    assign hit_card = (wb_adr_in == `SRCT_OFF_CARD);
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // Ack generation
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_in & wb_stb_in & ~ack_q;
    end

    // SDRAM control register, power-on reset only
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            sdram_q <= `SRCT_SDRAM_RST;
        else if (wr_req && hit_sdram)
        begin
            if (wb_sel_in[0])
                sdram_q[7:0] <= wb_dat_in[7:0] & 8'(`SRCT_SDRAM_WMASK);
            if (wb_sel_in[1])
                sdram_q[15:8] <= wb_dat_in[15:8];
        end
    end

    // Card strobe register; manual reset deliberately leaves it alone
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            card_q <= `SRCT_CARD_RST;
        else if (wr_req && hit_card)
        begin
            if (wb_sel_in[0])
                card_q[7:0] <= wb_dat_in[7:0];
            if (wb_sel_in[1])
                card_q[15:8] <= wb_dat_in[15:8] & 8'(`SRCT_CARD_WMASK >> 8);
        end
    end

    // Status view of the block's own state
    assign status = {11'h000, card_busy_out, amx_valid, rf_q == RF_HOLD, self_refresh_out};

    // Read mux, unmapped offsets read zero and ignore writes
    always_comb
    begin
        case (wb_adr_in)
            `SRCT_OFF_SDRAM: rdat_d = {16'h0000, sdram_q};
            `SRCT_OFF_CARD: rdat_d = {16'h0000, card_q};
            `SRCT_OFF_STATUS: rdat_d = {16'h0000, status};
            default: rdat_d = 32'h00000000;
        endcase
    end

    // Read data captured with the ack
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdat_q <= 32'h00000000;
        else if (wb_cyc_in && wb_stb_in && !ack_q)
            rdat_q <= rdat_d;
    end

    // ****************************************************************
    // Row address multiplex
    // ****************************************************************
    assign amx = sdram_q[`SRCT_AMX_LSB+3 -: 4];

    // Reserved codes select nothing, so A1 stays low
    always_comb
    begin
        amx_valid = 1'b1;
        case (amx)
            `SRCT_AMX_A10_X16: row_bit = sdram_addr_in[10];
            `SRCT_AMX_A11_X16: row_bit = sdram_addr_in[11];
            `SRCT_AMX_A9_X16: row_bit = sdram_addr_in[9];
            `SRCT_AMX_A10_X8: row_bit = sdram_addr_in[10];
            `SRCT_AMX_A9_X32: row_bit = sdram_addr_in[9];
            default:
            begin
                row_bit = 1'b0;
                amx_valid = 1'b0;
            end
        endcase
    end

    // Registered A1 drive during the row phase
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            row_a1_q <= 1'b0;
        else
            row_a1_q <= row_phase_in & row_bit;
    end
    assign row_a1_out = row_a1_q;

    // ****************************************************************
    // Refresh sequencer
    // ****************************************************************
    assign rf_en = sdram_q[`SRCT_BIT_REFRESH_EN];
    assign rf_kind = sdram_q[`SRCT_BIT_REFRESH_KIND];
    assign bus_busy = ext_bus_busy_in | (|card_busy_out);

    // One pending request at most; extra requests while waiting merge
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rf_q <= RF_IDLE;
            auto_q <= 1'b0;
        end
        else
        begin
            auto_q <= 1'b0;
            case (rf_q)
                RF_IDLE:
                begin
                    if (rf_en && rf_kind)
                        rf_q <= bus_busy ? RF_HOLD : RF_SELF;
                    else if (rf_en && refresh_req_in)
                    begin
                        rf_q <= bus_busy ? RF_HOLD : RF_AUTO;
                        auto_q <= ~bus_busy;
                    end
                end
                RF_HOLD:
                begin
                    if (!rf_en)
                        rf_q <= RF_IDLE;
                    else if (!bus_busy)
                    begin
                        rf_q <= rf_kind ? RF_SELF : RF_AUTO;
                        auto_q <= ~rf_kind;
                    end
                end
                RF_AUTO:
                begin
                    if (rf_en && rf_kind)
                        rf_q <= bus_busy ? RF_HOLD : RF_SELF;
                    else if (rf_en && refresh_req_in)
                        rf_q <= RF_HOLD;
                    else
                        rf_q <= RF_IDLE;
                end
                RF_SELF:
                begin
                    // Requests are not looked at here
                    if (!(rf_en && rf_kind))
                        rf_q <= RF_IDLE;
                end
                default: rf_q <= RF_IDLE;
            endcase
        end
    end
    assign auto_refresh_out = auto_q;
    assign self_refresh_out = (rf_q == RF_SELF);

    // Timer tick handed on as an interval event when refresh is off
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            tick_q <= 1'b0;
        else
            tick_q <= refresh_req_in & ~rf_en;
    end
    assign interval_tick_out = tick_q;

    // ****************************************************************
    // Card area timing fields (index 0 is area 5, 1 is area 6)
    // ****************************************************************
    assign wait_code[0] = {card_q[`SRCT_A5_WAIT_TOP], wait_low_bits_in[0]};
    assign wait_code[1] = {card_q[`SRCT_A6_WAIT_TOP], wait_low_bits_in[1]};
    assign assert_dly[0] = {card_q[`SRCT_A5_ASSERT_MSB], card_q[`SRCT_A5_ASSERT_LO+1 -: 2]};
    assign assert_dly[1] = {card_q[`SRCT_A6_ASSERT_MSB], card_q[`SRCT_A6_ASSERT_LO+1 -: 2]};
    assign hold_dly[0] = {card_q[`SRCT_A5_HOLD_MSB], card_q[`SRCT_A5_HOLD_LO+1 -: 2]};
    assign hold_dly[1] = {card_q[`SRCT_A6_HOLD_MSB], card_q[`SRCT_A6_HOLD_LO+1 -: 2]};

    // ****************************************************************
    // Card strobe engines
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_area
            srct_card_state_t cs_q;
            logic [5:0] cnt_q;
            logic [1:0] beats_q;
            logic wr_q;
            logic strobe_q;
            logic addr_q;
            logic beat_q;
            logic done_q;
            logic stall;

            srct_wait_decode u_dec (
                .code_in(wait_code[g]),
                .wait_out(wait_info[g])
            );

            // Wait pin stretches the strobe except on code-zero first cycles
            assign stall = card_wait_pin_in[g] & ~(wait_info[g].pin_ignored && cs_q == CS_STROBE);

            // Address window, strobe window and burst beats
            always_ff @(posedge mclk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    cs_q <= CS_IDLE;
                    cnt_q <= 6'h00;
                    beats_q <= 2'h0;
                    wr_q <= 1'b0;
                    strobe_q <= 1'b0;
                    addr_q <= 1'b0;
                    beat_q <= 1'b0;
                    done_q <= 1'b0;
                end
                else if (!manual_rstn_in)
                begin
                    cs_q <= CS_IDLE;
                    strobe_q <= 1'b0;
                    addr_q <= 1'b0;
                    beat_q <= 1'b0;
                    done_q <= 1'b0;
                end
                else
                begin
                    beat_q <= 1'b0;
                    done_q <= 1'b0;
                    case (cs_q)
                        CS_IDLE:
                        begin
                            if (card_req_in[g].start)
                            begin
                                addr_q <= 1'b1;
                                wr_q <= card_req_in[g].write;
                                beats_q <= card_req_in[g].beats;
                                if (assert_dly[g] == 3'h0)
                                begin
                                    strobe_q <= 1'b1;
                                    cnt_q <= wait_info[g].first_waits;
                                    cs_q <= CS_STROBE;
                                end
                                else
                                begin
                                    cnt_q <= {3'h0, 3'(assert_dly[g] - 3'h1)};
                                    cs_q <= CS_SETUP;
                                end
                            end
                        end
                        CS_SETUP:
                        begin
                            if (cnt_q == 6'h00)
                            begin
                                strobe_q <= 1'b1;
                                cnt_q <= wait_info[g].first_waits;
                                cs_q <= CS_STROBE;
                            end
                            else
                                cnt_q <= 6'(cnt_q - 6'h01);
                        end
                        CS_STROBE, CS_BURST:
                        begin
                            if (cnt_q != 6'h00)
                                cnt_q <= 6'(cnt_q - 6'h01);
                            else if (stall)
                                cnt_q <= 6'h00;
                            else if (beats_q != 2'h0)
                            begin
                                beats_q <= 2'(beats_q - 2'h1);
                                beat_q <= 1'b1;
                                cnt_q <= 6'(wait_info[g].burst_states - 6'h01);
                                cs_q <= CS_BURST;
                            end
                            else
                            begin
                                strobe_q <= 1'b0;
                                beat_q <= 1'b1;
                                cnt_q <= {3'h0, hold_dly[g]};
                                cs_q <= CS_HOLD;
                            end
                        end
                        CS_HOLD:
                        begin
                            if (cnt_q == 6'h00)
                            begin
                                addr_q <= 1'b0;
                                done_q <= 1'b1;
                                cs_q <= CS_IDLE;
                            end
                            else
                                cnt_q <= 6'(cnt_q - 6'h01);
                        end
                        default: cs_q <= CS_IDLE;
                    endcase
                end
            end

            srct_half_cycle_stage u_half (
                .mclk_in(mclk_in),
                .rstn_in(rstn_in),
                .strobe_in(strobe_q),
                .write_in(wr_q),
                .oe_n_out(card_oe_n_out[g]),
                .we_n_out(card_we_n_out[g])
            );

            assign card_addr_valid_out[g] = addr_q;
            assign card_beat_done_out[g] = beat_q;
            assign card_done_out[g] = done_q;
            assign card_busy_out[g] = (cs_q != CS_IDLE);
        end
    endgenerate
endmodule

// ==== test/srct_card_model.sv ====
`timescale 1ns/1ps
module srct_card_model (
    input wire logic mclk_in,
    input wire logic strobe_n_in,
    input wire logic stall_in,
    output logic wait_out
);
    int n = 0;
    // Counts strobe-low cycles; idle level of the wait line is low
    always @(posedge mclk_in)
        n <= strobe_n_in ? 0 : n + 1;
    // Wait follows the strobe at once, so the first strobe edge already sees it
    assign wait_out = stall_in && !strobe_n_in && n < 4;
endmodule

// ==== test/srct_top_asserts.sv ====
`timescale 1ns/1ps
module srct_top_asserts (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic ext_bus_busy_in,
    input wire logic auto_refresh_out,
    input wire logic self_refresh_out,
    input wire logic interval_tick_out,
    input wire logic [1:0] card_addr_valid_out,
    input wire logic [1:0] card_oe_n_out,
    input wire logic [1:0] card_we_n_out,
    input wire logic [1:0] card_done_out
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    logic [1:0] strobe_on;
    // Either strobe active per area
    assign strobe_on = ~(card_oe_n_out & card_we_n_out);
    sequence wb_req_s;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence win_close_s;
        $fell(card_addr_valid_out[0]);
    endsequence
    bus_ack_a: assert property (wb_req_s |=> wb_ack_out) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
    tick_excl_a: assert property (interval_tick_out |-> !auto_refresh_out && !self_refresh_out)
        else $error("tick with refresh");
    auto_idle_a: assert property (auto_refresh_out |-> !$past(ext_bus_busy_in))
        else $error("refresh in bus cycle");
    self_idle_a: assert property ($rose(self_refresh_out) |-> !$past(ext_bus_busy_in))
        else $error("self refresh in bus cycle");
    self_quiet_a: assert property (self_refresh_out |-> !auto_refresh_out)
        else $error("refresh in self refresh");
    strobe_win_a: assert property ((strobe_on & ~card_addr_valid_out) == 2'b00)
        else $error("strobe outside window");
    open_late_a: assert property ($rose(card_addr_valid_out[0]) |-> !$past(strobe_on[0]))
        else $error("strobe with address");
    close_done_a: assert property (win_close_s |-> card_done_out[0] && !strobe_on[0])
        else $error("window close");
endmodule
bind srct_top srct_top_asserts u_chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
    .ext_bus_busy_in(ext_bus_busy_in), .auto_refresh_out(auto_refresh_out),
    .self_refresh_out(self_refresh_out), .interval_tick_out(interval_tick_out),
    .card_addr_valid_out(card_addr_valid_out), .card_oe_n_out(card_oe_n_out),
    .card_we_n_out(card_we_n_out), .card_done_out(card_done_out));

// ==== test/srct_top_tb.sv ====
`timescale 1ns/1ps
`include "srct_params.svh"
module srct_top_tb;
    import srct_pkg::*;
    logic mclk_in = 0, rstn_in = 0, mrst_n = 1, cyc = 0, stb = 0, we = 0, row = 0;
    logic req = 0, busy = 0, stall = 0, ack, a1, auto_o, self_o, tick;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [11:0] sa = 0;
    logic [1:0][2:0] wl = 0;
    srct_card_req_t [1:0] creq = 0;
    logic [1:0] wpin, av, oe_n, we_n;
    logic [15:0] r;
    logic [3:0] codes[7] = '{4'hd, 4'he, 4'h4, 4'h5, 4'h7, 4'h0, 4'h3};
    int bits[7] = '{10, 11, 9, 10, 9, -1, -1};
    int wt[16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};
    int failures = 0, n_tests = 0, n_auto = 0, ts, tw, ta, d, h;
    srct_top u_srct_top (.mclk_in(mclk_in), .rstn_in(rstn_in), .manual_rstn_in(mrst_n),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .sdram_addr_in(sa),
        .row_phase_in(row), .row_a1_out(a1), .refresh_req_in(req), .ext_bus_busy_in(busy),
        .auto_refresh_out(auto_o), .self_refresh_out(self_o), .interval_tick_out(tick),
        .wait_low_bits_in(wl), .card_req_in(creq), .card_wait_pin_in(wpin),
        .card_addr_valid_out(av), .card_oe_n_out(oe_n), .card_we_n_out(we_n),
        .card_beat_done_out(), .card_done_out(), .card_busy_out());
    srct_card_model m5 (.mclk_in(mclk_in), .strobe_n_in(oe_n[0] & we_n[0]), .stall_in(stall),
        .wait_out(wpin[0]));
    srct_card_model m6 (.mclk_in(mclk_in), .strobe_n_in(oe_n[1] & we_n[1]), .stall_in(stall),
        .wait_out(wpin[1]));
    // Clock and auto-refresh pulse tally
    always #10 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (auto_o === 1'b1) n_auto <= n_auto + 1;
    task finish_test;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Classic single cycle; held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [15:0] dv);
        int n;
        n = 0;
        @(posedge mclk_in);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 16'h0000, dv};
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge mclk_in);
            n++;
        end
        if (n >= 20) failures++;
        r = rdat[15:0];
        {cyc, stb} <= 2'b00;
    endtask
    task rq;
        @(posedge mclk_in) req <= 1;
        @(posedge mclk_in) req <= 0;
        @(posedge mclk_in);
    endtask
    // Card register image for one area
    function automatic logic [15:0] creg(int a, logic t, logic [2:0] dd, logic [2:0] hh);
        return a == 0 ? {1'b0, t, 2'b00, dd[2], 1'b0, hh[2], 1'b0, dd[1:0], 2'b00, hh[1:0], 2'b00}
            : {t, 4'b0000, dd[2], 1'b0, hh[2], 2'b00, dd[1:0], 2'b00, hh[1:0]};
    endfunction
    // Counts edges to strobe, strobe samples and window samples
    task card(input int a, input logic [2:0] wlo);
        logic w;
        w = 1'($urandom % 2);
        ts = 0;
        tw = 0;
        ta = 0;
        @(posedge mclk_in) wl[a] <= wlo;
        @(posedge mclk_in) creq[a] <= '{1'b1, w, 2'b00};
        @(posedge mclk_in) creq[a] <= '0;
        for (int k = 1; k < 64; k++)
        begin
            @(posedge mclk_in);
            if ((w ? we_n[a] : oe_n[a]) === 1'b0)
            begin
                if (tw == 0) ts = k;
                tw++;
            end
            if (av[a] === 1'b1) ta++;
        end
    endtask
    initial
    begin
        #(20 * 20000);
        failures++;
        finish_test;
    end
    initial
    begin
        void'($urandom(32'h4657fa2a));
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1;
        wb(0, `SRCT_OFF_CARD, 0);
        chk("card rst", r, 0);
        wb(1, `SRCT_OFF_CARD, 16'hffff);
        wb(0, `SRCT_OFF_CARD, 0);
        chk("card rw", r, 16'hcfff);
        @(posedge mclk_in) mrst_n <= 0;
        @(posedge mclk_in) mrst_n <= 1;
        wb(0, `SRCT_OFF_CARD, 0);
        chk("card kept", r, 16'hcfff);
        wb(1, `SRCT_OFF_SDRAM, 16'h0001);
        wb(0, `SRCT_OFF_SDRAM, 0);
        chk("sdram bit0", r, 0);
        wb(1, 8'h40, 16'h1234);
        wb(0, 8'h40, 0);
        chk("unmapped", r, 0);
        $display("test regs done");
        row <= 1;
        foreach (codes[i])
        begin
            wb(1, `SRCT_OFF_SDRAM, {9'h000, codes[i], 3'b000});
            @(posedge mclk_in) sa <= 12'($urandom);
            repeat (2) @(posedge mclk_in);
            chk("row a1", a1, bits[i] < 0 ? 1'b0 : sa[bits[i]]);
        end
        $display("test row done");
        rq;
        chk("tick", tick, 1);
        chk("off", n_auto, 0);
        busy <= 1;
        wb(1, `SRCT_OFF_SDRAM, 16'h0004);
        rq;
        repeat (4) @(posedge mclk_in);
        chk("held", n_auto, 0);
        busy <= 0;
        repeat (3) @(posedge mclk_in);
        chk("auto", n_auto, 1);
        busy <= 1;
        wb(1, `SRCT_OFF_SDRAM, 16'h0006);
        repeat (3) @(posedge mclk_in);
        chk("self wait", self_o, 0);
        busy <= 0;
        repeat (3) @(posedge mclk_in);
        chk("self", self_o, 1);
        wb(0, `SRCT_OFF_STATUS, 0);
        chk("status", r, 16'h0001);
        rq;
        repeat (3) @(posedge mclk_in);
        chk("ignored", n_auto, 1);
        wb(1, `SRCT_OFF_SDRAM, 0);
        $display("test refresh done");
        for (int c = 0; c < 16; c++)
        begin
            d = $urandom % 8;
            h = $urandom % 8;
            wb(1, `SRCT_OFF_CARD, creg(c % 2, c[3], d[2:0], h[2:0]));
            card(c % 2, c[2:0]);
            chk("assert", ts, d + 1);
            chk("width", tw, wt[c] + 1);
            chk("hold", ta, d + wt[c] + h + 2);
        end
        stall <= 1;
        wb(1, `SRCT_OFF_CARD, 0);
        card(0, 3'd0);
        chk("pin off", tw, 1);
        card(0, 3'd1);
        chk("pin on", tw > 2, 1);
        $display("test card done");
        finish_test;
    end
endmodule
